// ==== adc_status_mode_regs.sv ====
/*
  Identification, status and mode registers of a four-channel converter,
  reached through a simple synchronous register port fed by the serial
  interface decoder. Assumes event pulses from device logic on CLK_SYS.
*/
// What this block does
// - Identification bits 11:8 report four channels
// - Identification low byte is fixed revision value
// - Status bit 15 mirrors interface lock
// - Status bit 14 set on each resync
// - Status bit 13 flags register-map checksum change
// - Status bit 12 flags input CRC error
// - Status bit 10 set by reset, mode clears
// - Status bits 9:8 mirror word length
// - Status bits 3:0 are new-data flags
// - Mode bit 13 enables map checksum
// - Mode bit 12 enables input CRC check
// - Mode bit 11 selects CCITT or ANSI
// - Mode bits 9:8 set word length
// - Mode bit 4 enables interface timeout
`timescale 1ns/100ps
`include "adc_regs_consts.svh"
module adc_status_mode_regs (
  // Clock and reset
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESETN,
  // Register port
  input  wire logic                        REG_WRITE,
  input  wire logic                        REG_READ,
  input  wire logic [5:0]                  REG_ADDR,
  input  wire logic [15:0]                 REG_WDATA,
  output      logic [15:0]                 REG_RDATA,
  output      logic                        REG_RVALID,
  // Device events and levels
  input  wire logic                        INTERFACE_LOCKED,
  input  wire logic                        RESYNC_EVENT,
  input  wire logic                        MAP_CRC_CHANGED,
  input  wire logic                        MAP_CRC_CLEAR,
  input  wire logic                        IN_CRC_ERROR,
  input  wire logic                        IN_CRC_CLEAR,
  input  wire logic                        RESYNC_CLEAR,
  input  wire logic [3:0]                  SAMPLE_READY,
  input  wire logic [3:0]                  SAMPLE_TAKEN,
  // Configuration outputs
  output      logic                        MAP_CRC_ENABLE,
  output      logic                        IN_CRC_ENABLE,
  output      adc_regs_pkg::crc_kind_t     CRC_KIND,
  output      adc_regs_pkg::word_size_t    SAMPLE_WORD_SIZE,
  output      logic                        TIMEOUT_ENABLE
);
  adc_regs_pkg::reg_word_t interface_operating_setup;
  adc_regs_pkg::reg_word_t next_interface_operating_setup;
  adc_regs_pkg::reg_word_t device_condition_flags;
  adc_regs_pkg::reg_word_t next_rdata;
  logic                    next_rvalid;
  logic                    lock_level;
  logic                    next_lock_level;
  logic                    reset_seen;
  logic                    next_reset_seen;
  logic [2:0]              event_flags;
  logic [3:0]              new_sample_flags;
  logic [3:0]              channel_total_field;
  logic                    resync_occurred_flag;
  logic                    map_crc_changed_flag;
  logic                    in_crc_error_flag;
  logic                    ch0_new_sample_flag;
  logic                    ch1_new_sample_flag;
  logic                    ch2_new_sample_flag;
  logic                    ch3_new_sample_flag;
  logic                    setup_write;
  logic                    ident_read;
  logic                    flags_read;

  // Identification word: fixed top nibble, channel count, revision byte
  function automatic adc_regs_pkg::reg_word_t device_identification(input logic [3:0] count);
    device_identification = {`IDENT_UPPER_NIBBLE, count, `IDENT_REVISION};
  endfunction : device_identification

  assign channel_total_field  = `IDENT_CHANNEL_TOTAL;
  assign setup_write          = REG_WRITE && (REG_ADDR == `ADDR_SETUP);
  assign ident_read           = REG_READ && (REG_ADDR == `ADDR_IDENT);
  assign flags_read           = REG_READ && (REG_ADDR == `ADDR_FLAGS);
  assign resync_occurred_flag = event_flags[2];
  assign map_crc_changed_flag = event_flags[1];
  assign in_crc_error_flag    = event_flags[0];
  assign ch0_new_sample_flag  = new_sample_flags[0];
  assign ch1_new_sample_flag  = new_sample_flags[1];
  assign ch2_new_sample_flag  = new_sample_flags[2];
  assign ch3_new_sample_flag  = new_sample_flags[3];

  // Status word is assembled live; only its sources hold state
  assign device_condition_flags = {lock_level, resync_occurred_flag, map_crc_changed_flag, in_crc_error_flag,
                                   interface_operating_setup[`BIT_CRC_KIND], reset_seen,
                                   interface_operating_setup[`BIT_WORD_HI:`BIT_WORD_LO], 4'h0,
                                   ch3_new_sample_flag, ch2_new_sample_flag, ch1_new_sample_flag,
                                   ch0_new_sample_flag};

  // Resync, map checksum and input CRC flags
  sticky_flag_bank #(
    .WIDTH      (3),
    .RESET_BITS (4'h0)
  ) u_event_flags (
    .clk    (CLK_SYS),
    .resetn (RESETN),
    .set    ({RESYNC_EVENT, MAP_CRC_CHANGED & interface_operating_setup[`BIT_MAP_CRC],
              IN_CRC_ERROR & interface_operating_setup[`BIT_IN_CRC]}),
    .clr    ({RESYNC_CLEAR, MAP_CRC_CLEAR, IN_CRC_CLEAR}),
    .flags  (event_flags)
  );

  // One new-data flag per channel
  sticky_flag_bank #(
    .WIDTH      (`CHANNELS),
    .RESET_BITS (4'h0)
  ) u_sample_flags (
    .clk    (CLK_SYS),
    .resetn (RESETN),
    .set    (SAMPLE_READY),
    .clr    (SAMPLE_TAKEN),
    .flags  (new_sample_flags)
  );

  always_comb begin
    next_interface_operating_setup = interface_operating_setup;
    next_reset_seen                = reset_seen;
    next_lock_level                = INTERFACE_LOCKED;
    if (setup_write) begin
      // Reserved bits are held at zero whatever the host sends
      next_interface_operating_setup = REG_WDATA & `SETUP_WRITE_MASK;
      // Writing 1 never sets the reset flag; only a device reset does
      if (!REG_WDATA[`BIT_RESET_SEEN]) begin
        next_reset_seen = 1'h0;
      end
    end
  end

  always_comb begin
    next_rvalid = REG_READ;
    next_rdata  = 16'h0000;
    if (REG_READ) begin
      case (REG_ADDR)
        `ADDR_IDENT: next_rdata = device_identification(channel_total_field);
        `ADDR_FLAGS: next_rdata = device_condition_flags;
        `ADDR_SETUP: next_rdata = {interface_operating_setup[15:11], reset_seen, interface_operating_setup[9:0]};
        default:     next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      interface_operating_setup <= `SETUP_RESET;
      reset_seen                <= 1'h1;
      lock_level                <= 1'h0;
      REG_RDATA                 <= 16'h0000;
      REG_RVALID                <= 1'h0;
    end else begin
      interface_operating_setup <= next_interface_operating_setup;
      reset_seen                <= next_reset_seen;
      lock_level                <= next_lock_level;
      REG_RDATA                 <= next_rdata;
      REG_RVALID                <= next_rvalid;
    end
  end

  assign MAP_CRC_ENABLE   = interface_operating_setup[`BIT_MAP_CRC];
  assign IN_CRC_ENABLE    = interface_operating_setup[`BIT_IN_CRC];
  assign CRC_KIND         = adc_regs_pkg::crc_kind_t'(interface_operating_setup[`BIT_CRC_KIND]);
  assign SAMPLE_WORD_SIZE = interface_operating_setup[`BIT_WORD_HI:`BIT_WORD_LO];
  assign TIMEOUT_ENABLE   = interface_operating_setup[`BIT_TIMEOUT];

  AST_IDENT_COUNT: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    ident_read |=> REG_RVALID && REG_RDATA[11:8] == `IDENT_CHANNEL_TOTAL)
    else $error("channel count wrong");
  AST_IDENT_LOW: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    ident_read |=> REG_RDATA[7:0] == `IDENT_REVISION)
    else $error("revision byte changed");
  AST_LOCK: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    flags_read |=> REG_RDATA[`BIT_LOCK] == $past(lock_level))
    else $error("lock bit mismatch");
  AST_LOCK_FOLLOW: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $past(RESETN) |-> lock_level == $past(INTERFACE_LOCKED))
    else $error("lock level does not follow interface");
  AST_RESYNC: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    RESYNC_EVENT |=> resync_occurred_flag)
    else $error("resync flag not set");
  AST_RESYNC_IDLE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !RESYNC_EVENT && !resync_occurred_flag |=> !resync_occurred_flag)
    else $error("resync flag rose without event");
  AST_MAP: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    MAP_CRC_CHANGED && interface_operating_setup[`BIT_MAP_CRC] |=> map_crc_changed_flag)
    else $error("map crc flag not set");
  AST_MAP_OFF: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !interface_operating_setup[`BIT_MAP_CRC] && !map_crc_changed_flag |=> !map_crc_changed_flag)
    else $error("map crc flag set while checksum disabled");
  AST_INCRC: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    IN_CRC_ERROR && interface_operating_setup[`BIT_IN_CRC] |=> in_crc_error_flag)
    else $error("input crc flag not set");
  AST_INCRC_OFF: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !interface_operating_setup[`BIT_IN_CRC] && !in_crc_error_flag |=> !in_crc_error_flag)
    else $error("input crc flag set while check disabled");
  AST_RSTCLR: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    setup_write && !REG_WDATA[`BIT_RESET_SEEN] |=> !reset_seen)
    else $error("reset flag not cleared");
  AST_RSTHOLD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !reset_seen |=> !reset_seen)
    else $error("reset flag rose without reset");
  AST_WORD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    setup_write |=> SAMPLE_WORD_SIZE == $past(REG_WDATA[`BIT_WORD_HI:`BIT_WORD_LO]))
    else $error("word size not taken");
  AST_WORD_STATUS: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    flags_read |=> REG_RDATA[`BIT_WORD_HI:`BIT_WORD_LO] == $past(SAMPLE_WORD_SIZE))
    else $error("status word size differs from mode");
  AST_RSVD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    REG_RVALID && $past(REG_ADDR) == `ADDR_FLAGS |-> REG_RDATA[7:4] == 4'h0)
    else $error("reserved status bits set");
  AST_SAMPLE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    SAMPLE_READY[0] |=> ch0_new_sample_flag)
    else $error("new sample flag lost");
  AST_SAMPLE_CLR: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    SAMPLE_TAKEN[0] && !SAMPLE_READY[0] |=> !ch0_new_sample_flag)
    else $error("new sample flag not cleared");
  AST_SETUP_RSVD: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    setup_write |=> interface_operating_setup[15:14] == 2'h0 && interface_operating_setup[7:5] == 3'h0)
    else $error("reserved mode bits stored");
  AST_CRC_KIND: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    setup_write |=> CRC_KIND == $past(REG_WDATA[`BIT_CRC_KIND]))
    else $error("crc kind not taken");
  AST_MAP_EN: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    setup_write |=> MAP_CRC_ENABLE == $past(REG_WDATA[`BIT_MAP_CRC]))
    else $error("map checksum enable not taken");
  AST_IN_EN: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    setup_write |=> IN_CRC_ENABLE == $past(REG_WDATA[`BIT_IN_CRC]))
    else $error("input crc enable not taken");
  AST_TIMEOUT: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    setup_write |=> TIMEOUT_ENABLE == $past(REG_WDATA[`BIT_TIMEOUT]))
    else $error("timeout enable not taken");
endmodule : adc_status_mode_regs

// ==== adc_regs_consts.svh ====
/*
  Offsets, field positions, reset values and encodings of the identification,
  status and mode registers. Assumes inclusion by bare name from design files.
*/
`ifndef ADC_REGS_CONSTS_SVH
`define ADC_REGS_CONSTS_SVH

`define ADDR_IDENT        6'h00
`define ADDR_FLAGS        6'h01
`define ADDR_SETUP        6'h02

`define IDENT_UPPER_NIBBLE  4'hA  // Arbitrary value
`define IDENT_CHANNEL_TOTAL 4'h4
`define IDENT_REVISION      8'h00 // Arbitrary value

`define FLAGS_RESET       16'h0500
`define SETUP_RESET       16'h0510
`define SETUP_WRITE_MASK  16'h3F1F

`define BIT_LOCK          15
`define BIT_RESYNC        14
`define BIT_MAP_CRC       13
`define BIT_IN_CRC        12
`define BIT_CRC_KIND      11
`define BIT_RESET_SEEN    10
`define BIT_WORD_HI       9
`define BIT_WORD_LO       8
`define BIT_TIMEOUT       4

`define WORD_16           2'h0
`define WORD_24           2'h1
`define WORD_32_PAD       2'h2
`define WORD_32_SIGN      2'h3

`define CHANNELS          4

`endif

// ==== adc_regs_pkg.sv ====
/*
  Types shared by the register bank. Assumes the constants header alongside.
*/
package adc_regs_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [1:0]  word_size_t;
  typedef enum logic   {CRC_CCITT, CRC_ANSI} crc_kind_t;
endpackage : adc_regs_pkg

// ==== sticky_flag_bank.sv ====
/*
  Bank of sticky event flags: set by a pulse, cleared by a pulse, set wins.
  Assumes set and clear inputs are synchronous to CLK_SYS.
*/
`timescale 1ns/100ps
module sticky_flag_bank #(
  parameter int          WIDTH      = 4,
  parameter logic [3:0]  RESET_BITS = 4'h0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Events
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // State
  output      logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] next_flags;

  always_comb begin
    next_flags = (flags & ~clr) | set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags <= RESET_BITS[WIDTH-1:0];
    end else begin
      flags <= next_flags;
    end
  end
endmodule : sticky_flag_bank

// ==== reg_host.sv ====
/*
  Host-side driver of the register port: one-cycle read and write strobes.
  Assumes read data and its valid flag arrive one cycle after the read edge.
*/
`timescale 1ns/100ps
module reg_host (
  // Clock
  input  wire logic        clk,
  // Register port
  output      logic        wr,
  output      logic        rd,
  output      logic [5:0]  addr,
  output      logic [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  initial begin
    wr = 1'h0;
    rd = 1'h0;
    addr = 6'h00;
    wdata = 16'h0000;
  end

  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d & 16'h3F1F;
    @(posedge clk);
    wr <= 1'h0;
    wdata <= ~d;
  endtask : write

  task automatic read(input logic [5:0] a, output logic [15:0] q, output logic v);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    v = rvalid;
    q = rdata;
  endtask : read
endmodule : reg_host

// ==== tb.sv ====
/*
  Self-checking bench of the status and mode register bank.
  Assumes the host driver model and the design files compiled before it.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
  logic                     clk, resetn, lock, wr, rd, rv, mce, ice, toe, v, rf;
  logic [5:0]               ad;
  logic [6:0]               ev, cl, s, c, fl;
  logic [15:0]              wd, rdt, m, q, d;
  adc_regs_pkg::crc_kind_t  kind;
  adc_regs_pkg::word_size_t ws;
  int                       errors, n_tests, seed, i;

  reg_host host (.clk(clk), .wr(wr), .rd(rd), .addr(ad), .wdata(wd), .rdata(rdt), .rvalid(rv));
  adc_status_mode_regs dut (.CLK_SYS(clk), .RESETN(resetn), .REG_WRITE(wr), .REG_READ(rd), .REG_ADDR(ad),
    .REG_WDATA(wd), .REG_RDATA(rdt), .REG_RVALID(rv), .INTERFACE_LOCKED(lock), .RESYNC_EVENT(ev[6]),
    .MAP_CRC_CHANGED(ev[5]), .IN_CRC_ERROR(ev[4]), .SAMPLE_READY(ev[3:0]), .RESYNC_CLEAR(cl[6]),
    .MAP_CRC_CLEAR(cl[5]), .IN_CRC_CLEAR(cl[4]), .SAMPLE_TAKEN(cl[3:0]), .MAP_CRC_ENABLE(mce),
    .IN_CRC_ENABLE(ice), .CRC_KIND(kind), .SAMPLE_WORD_SIZE(ws), .TIMEOUT_ENABLE(toe));

  function automatic logic [15:0] exp_status();
    return {lock, fl[6:4], m[11], rf, m[9:8], 4'h0, fl[3:0]};
  endfunction : exp_status

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic check_all;
    host.read(6'h00, q, v);
    `CHK(v, 1'h1)
    `CHK(q[11:8], 4'h4)
    host.read(6'h01, q, v);
    `CHK(q, exp_status())
    host.read(6'h02, q, v);
    `CHK(q, (m & 16'hFBFF) | {5'h00, rf, 10'h000})
    `CHK({mce, ice, kind, ws, toe}, {m[13:11], m[9:8], m[4]})
    host.read(6'h2A, q, v);
    `CHK(q, 16'h0000)
  endtask : check_all

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(3000 * 100);
    errors++;
    stop_test;
  end

  initial begin
    seed = 32'h01847CF3;
    {lock, ev, cl} = 15'h0000;
    resetn = 1'h0;
    m = 16'h0510;
    rf = 1'h1;
    fl = 7'h00;
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    check_all;
    $display("test reset values done");
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      lock <= 1'($random(seed));
      d = 16'($random(seed));
      if (i % 3 == 0) begin
        // Ident and status must ignore writes; mode takes them
        host.write(6'(i % 9 / 3), d);
        if (i % 9 == 6) begin
          m = d & 16'h3F1F;
          rf = rf & d[10];
        end
      end else begin
        s = 7'($random(seed));
        c = 7'($random(seed));
        @(posedge clk);
        ev <= s;
        cl <= c;
        @(posedge clk);
        ev <= 7'h00;
        cl <= 7'h00;
        s[5] = s[5] & m[13];
        s[4] = s[4] & m[12];
        fl = (fl & ~c) | s;
      end
      check_all;
    end
    $display("test random traffic done");
    @(posedge clk);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    m = 16'h0510;
    rf = 1'h1;
    fl = 7'h00;
    check_all;
    $display("test second reset done");
    stop_test;
  end
endmodule : tb
